// *** scf_pkg.sv ***
// scf_pkg: constants, types and helpers for the sync framer and block check
// Summary of operation
// - enter sync search on start or dropout
// - shift bits into window, compare with sync
// - after match, flag a character every eight bits
// - no match: shift one bit, compare again
// - optionally require two successive sync characters
// - accumulate block check over every block character
// - longitudinal check: per-bit xor, parity included
// - compare received check with local, flag result
// - cyclic check keeps modulo-2 division remainder
// - crc-16 mode, generator x16+x15+x2+1
// - crc-ccitt mode, generator x16+x12+x5+1
package scf_pkg;
    localparam int CHAR_BITS = 8; // bits per character
    localparam int ACC_W = 16; // widest check value
    localparam int AW = 8; // bus address width
    localparam int DW = 32; // bus data width
    // register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SYNC = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0c;
    localparam logic [7:0] A_DATA = 8'h10;
    localparam logic [7:0] A_CHK = 8'h14;
    localparam logic [7:0] A_STATE = 8'h18;
    // control bit positions
    localparam int C_EN = 0;
    localparam int C_HUNT = 1;
    localparam int C_MODE = 2; // two bits
    localparam int C_DUAL = 4;
    localparam int C_CLR = 5;
    localparam int C_TAIL = 6;
    // status bit positions
    localparam int S_CHAR = 0;
    localparam int S_SYNC = 1;
    localparam int S_GOOD = 2;
    localparam int S_BAD = 3;
    localparam int S_OVR = 4;
    localparam int S_DROP = 5;
    localparam int NSTS = 6;
    localparam logic [7:0] SYNC_RST = 8'h16; // sync character after reset
    // generators without the implicit x^16 term
    localparam logic [15:0] POLY_CRC16 = 16'h8005;
    localparam logic [15:0] POLY_CCITT = 16'h1021;
    // line silence that counts as a dropout, a least time
    localparam int CLK_PERIOD_NS = 10;
    localparam int DROP_NS = 20000;
    localparam int DROP_CYC = (DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    typedef enum logic [1:0] {SCF_LRC, SCF_CRC16, SCF_CCITT} scf_mode_e;
    typedef enum logic [1:0] {ST_OFF, ST_HUNT, ST_HUNT2, ST_FRAMED} scf_state_e;
    // one character through the divider, bits in line order (bit 0 first)
    function automatic logic [15:0] scf_crc_byte(input logic [15:0] acc,
        input logic [7:0] d, input logic [15:0] poly);
        logic [15:0] r;
        logic fb;
        r = acc;
        for (int i = 0; i < CHAR_BITS; i++) begin
            fb = r[15] ^ d[i];
            r = {r[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
        end
        return r;
    endfunction
endpackage

// *** scf_chk_if.sv ***
// scf_chk_if: character path from the framer into the block check
`timescale 1ns/1ps
interface scf_chk_if;
    import scf_pkg::*;
    logic stb; // one character this cycle
    logic [7:0] chr; // the character, parity included
    logic clr; // start of a new block
    scf_mode_e mode; // check method
    logic [15:0] acc; // running check value
    modport ctl (output stb, output chr, output clr, output mode, input acc);
    modport sink (input stb, input chr, input clr, input mode, output acc);
endinterface

// *** scf_sync_hunt.sv ***
// scf_sync_hunt: eight-bit line window and its sync comparator
`timescale 1ns/1ps
module scf_sync_hunt import scf_pkg::*; #(
    parameter int W = CHAR_BITS
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic bit_stb,
    input wire logic bit_in,
    input wire logic [W-1:0] sync_chr,
    output logic [W-1:0] win,
    output logic shifted,
    output logic match
);
    logic [W-1:0] win_shift; // window after one more bit

    // newest bit enters at the top, oldest drops off bit 0
    assign win_shift = {bit_in, win[W-1:1]};

    // window and the strobe that says it just moved
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            win <= '0;
            shifted <= 1'b0;
        end else if (ce) begin
            shifted <= bit_stb;
            if (bit_stb) begin
                win <= win_shift;
            end
        end
    end

    // whole window against the programmed character at once
    assign match = (win == sync_chr);

    a_window_shift: assert property (
        @(posedge mclk) disable iff (!nrst)
        ce && bit_stb |=> shifted && win == $past(win_shift))
        else $error("window did not take exactly one bit");
endmodule

// *** scf_check_acc.sv ***
// scf_check_acc: block check accumulator for longitudinal and cyclic checks
`timescale 1ns/1ps
module scf_check_acc import scf_pkg::*; (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    scf_chk_if.sink chk
);
    logic [15:0] acc_reg; // running check value

    // fold each block character into the check; clear wins over a character
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_reg <= '0;
        end else if (ce) begin
            if (chk.clr) begin
                acc_reg <= '0;
            end else if (chk.stb) begin
                case (chk.mode)
                    SCF_CRC16: acc_reg <= scf_crc_byte(acc_reg, chk.chr, POLY_CRC16);
                    SCF_CCITT: acc_reg <= scf_crc_byte(acc_reg, chk.chr, POLY_CCITT);
                    // longitudinal, also the fallback for the unused code
                    default: acc_reg <= {8'h00, acc_reg[7:0] ^ chk.chr};
                endcase
            end
        end
    end

    assign chk.acc = acc_reg;

    a_lrc_fold: assert property (
        @(posedge mclk) disable iff (!nrst)
        ce && !chk.clr && chk.stb && chk.mode == SCF_LRC
        |=> acc_reg == (($past(acc_reg) ^ {8'h00, $past(chk.chr)}) & 16'h00ff))
        else $error("longitudinal check is not the xor of the block");

    a_crc16_step: assert property (
        @(posedge mclk) disable iff (!nrst)
        ce && !chk.clr && chk.stb && chk.mode == SCF_CRC16
        |=> acc_reg == scf_crc_byte($past(acc_reg), $past(chk.chr), 16'h8005))
        else $error("crc-16 remainder wrong");

    a_ccitt_step: assert property (
        @(posedge mclk) disable iff (!nrst)
        ce && !chk.clr && chk.stb && chk.mode == SCF_CCITT
        |=> acc_reg == scf_crc_byte($past(acc_reg), $past(chk.chr), 16'h1021))
        else $error("crc-ccitt remainder wrong");

    a_block_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        ce && chk.clr |=> acc_reg == 16'h0000)
        else $error("check not cleared at block start");
endmodule

// *** scf_framer.sv ***
// scf_framer: sync search, character framing and block check for a serial line
//
// Local design decisions: the address map and the Wishbone slave port.
`timescale 1ns/1ps
module scf_framer import scf_pkg::*; #(
    parameter int DROP_CYCLES = DROP_CYC // silence that forces a re-search
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DW-1:0] wb_dat_i,
    output logic [DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic line_clk,
    input wire logic line_data,
    output logic irq,
    output logic [7:0] rx_char,
    output logic char_ready,
    output logic framed
);
    localparam int CW = $clog2(CHAR_BITS);
    localparam logic [CW-1:0] CNT_LAST = CW'(CHAR_BITS - 1);
    localparam int IW = $clog2(DROP_CYCLES + 1);
    localparam logic [IW-1:0] IDLE_LAST = IW'(DROP_CYCLES - 1);

    // pin synchronisers, stage 0 is read only by stage 1
    logic [2:0] lclk_sync_reg;
    logic [2:0] ldat_sync_reg;
    logic lclk_f_reg; // filtered bit clock
    logic ldat_f_reg; // filtered line data
    logic lclk_d_reg; // filtered clock, one cycle older
    logic bit_stb; // rising bit clock edge seen

    // software settings
    logic en_reg; // receiver on
    scf_mode_e mode_reg; // check method
    logic dual_reg; // two sync characters needed
    logic [7:0] sync_reg; // sync character
    logic [NSTS-1:0] sts_reg; // sticky events
    logic [NSTS-1:0] mask_reg; // interrupt mask
    // framing state
    scf_state_e st_reg;
    logic [CW-1:0] cnt_reg; // bit within a character
    logic [IW-1:0] idle_reg; // cycles since the last bit
    // block check tail
    logic tail_reg; // next characters are the sent check
    logic tail_cnt_reg; // check characters taken so far
    logic [15:0] rcv_reg; // check value from the line
    logic cmp_reg; // compare this cycle
    // output flops
    logic [7:0] rx_char_reg;
    logic char_ready_reg;
    logic framed_reg; // framed state, one cycle behind the state flop
    logic irq_reg;
    logic ack_reg;
    logic [DW-1:0] dat_reg;
    // window side
    logic [7:0] win;
    logic bit_ev; // window moved last cycle
    logic match;
    // bus decode and events
    logic req, wr, wr_ctrl, hunt_cmd, clr_cmd, tail_cmd, en_next;
    logic start, dropout, enter_search, sync_found, char_ev, tail_last, good;
    logic [NSTS-1:0] sts_set; // events raised this cycle
    logic [NSTS-1:0] sts_w1c; // bits software clears this cycle

    scf_chk_if chk();

    // three flops per pin; a change is taken once stages 1 and 2 agree
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            lclk_sync_reg <= '0;
            ldat_sync_reg <= '0;
            lclk_f_reg <= 1'b0;
            ldat_f_reg <= 1'b0;
            lclk_d_reg <= 1'b0;
        end else if (ce) begin
            lclk_sync_reg <= {lclk_sync_reg[1:0], line_clk};
            ldat_sync_reg <= {ldat_sync_reg[1:0], line_data};
            if (lclk_sync_reg[1] == lclk_sync_reg[2]) begin
                lclk_f_reg <= lclk_sync_reg[2];
            end
            if (ldat_sync_reg[1] == ldat_sync_reg[2]) begin
                ldat_f_reg <= ldat_sync_reg[2];
            end
            lclk_d_reg <= lclk_f_reg;
        end
    end

    // both pins see the same delay, so data is still steady at the edge;
    // the modem is expected to change data away from the rising edge
    assign bit_stb = ce & lclk_f_reg & ~lclk_d_reg;

    scf_sync_hunt #(
        .W(CHAR_BITS)
    ) u_hunt (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .bit_stb(bit_stb),
        .bit_in(ldat_f_reg),
        .sync_chr(sync_reg),
        .win(win),
        .shifted(bit_ev),
        .match(match)
    );

    // bus request not yet answered; writes use byte lane 0 only
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign wr_ctrl = wr && (wb_adr_i == A_CTRL);
    assign hunt_cmd = wr_ctrl & wb_dat_i[C_HUNT];
    assign clr_cmd = wr_ctrl & wb_dat_i[C_CLR];
    assign tail_cmd = wr_ctrl & wb_dat_i[C_TAIL];
    assign en_next = wr_ctrl ? wb_dat_i[C_EN] : en_reg;
    assign start = wr_ctrl & wb_dat_i[C_EN] & ~en_reg;

    // framed line went quiet for too long
    assign dropout = (st_reg == ST_FRAMED) && !bit_ev && (idle_reg == IDLE_LAST);
    // search again on start, on command or on dropout
    assign enter_search = en_next & (start | hunt_cmd | dropout);
    // a sync match that ends the search
    assign sync_found = bit_ev & match
        & (((st_reg == ST_HUNT) & ~dual_reg)
        | ((st_reg == ST_HUNT2) & (cnt_reg == CNT_LAST)));
    // a full character every eight bits once framed
    assign char_ev = bit_ev && (st_reg == ST_FRAMED) && (cnt_reg == CNT_LAST);
    // longitudinal check sends one character, cyclic checks two
    assign tail_last = tail_cnt_reg | (mode_reg == SCF_LRC);
    // sent against local check value
    assign good = (mode_reg == SCF_LRC) ? (chk.acc[7:0] == rcv_reg[7:0])
        : (chk.acc == rcv_reg);
    // feed block characters, not the check characters themselves
    assign chk.stb = char_ev & ~tail_reg;
    assign chk.chr = win;
    assign chk.mode = mode_reg;
    // a new block starts on command, after a verdict, or on a new search
    assign chk.clr = clr_cmd | cmp_reg | enter_search;

    scf_check_acc u_check (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .chk(chk)
    );

    // settings written by software
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            en_reg <= 1'b0;
            mode_reg <= SCF_LRC;
            dual_reg <= 1'b0;
            sync_reg <= SYNC_RST;
            mask_reg <= '0;
        end else if (ce && wr) begin
            if (wb_adr_i == A_CTRL) begin
                en_reg <= wb_dat_i[C_EN];
                // spare code taken as longitudinal, so tail length and compare agree
                mode_reg <= (wb_dat_i[C_MODE +: 2] == 2'h3) ? SCF_LRC
                    : scf_mode_e'(wb_dat_i[C_MODE +: 2]);
                dual_reg <= wb_dat_i[C_DUAL];
            end
            if (wb_adr_i == A_SYNC) begin
                sync_reg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == A_MASK) begin
                mask_reg <= wb_dat_i[NSTS-1:0];
            end
        end
    end

    // framing state machine, advanced once per received bit
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= ST_OFF;
            cnt_reg <= '0;
        end else if (ce) begin
            if (!en_next) begin
                // receiver off
                st_reg <= ST_OFF;
                cnt_reg <= '0;
            end else if (enter_search) begin
                st_reg <= ST_HUNT;
                cnt_reg <= '0;
            end else if (bit_ev) begin
                unique case (st_reg)
                    ST_OFF: begin
                        cnt_reg <= '0;
                    end
                    ST_HUNT: begin
                        // a miss keeps sliding one bit at a time
                        if (match) begin
                            st_reg <= dual_reg ? ST_HUNT2 : ST_FRAMED;
                        end
                        cnt_reg <= '0;
                    end
                    ST_HUNT2: begin
                        // the next full character must be sync again
                        if (cnt_reg == CNT_LAST) begin
                            st_reg <= match ? ST_FRAMED : ST_HUNT;
                            cnt_reg <= '0;
                        end else begin
                            cnt_reg <= cnt_reg + CW'(1);
                        end
                    end
                    ST_FRAMED: begin
                        // wraps every character
                        cnt_reg <= cnt_reg + CW'(1);
                    end
                endcase
            end
        end
    end

    // silence watchdog; only a framed line can drop out
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            idle_reg <= '0;
        end else if (ce) begin
            if (bit_ev || st_reg != ST_FRAMED || dropout) begin
                idle_reg <= '0;
            end else begin
                idle_reg <= idle_reg + IW'(1);
            end
        end
    end

    // check characters at block end are captured, then compared
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tail_reg <= 1'b0;
            tail_cnt_reg <= 1'b0;
            rcv_reg <= '0;
            cmp_reg <= 1'b0;
        end else if (ce) begin
            cmp_reg <= char_ev & tail_reg & tail_last;
            if (enter_search) begin
                // a broken block has no verdict
                tail_reg <= 1'b0;
                tail_cnt_reg <= 1'b0;
            end else if (tail_cmd) begin
                tail_reg <= 1'b1;
                tail_cnt_reg <= 1'b0;
            end else if (char_ev && tail_reg) begin
                // with two check characters the first ends up in the high byte; a single one stays in the low byte
                rcv_reg <= {rcv_reg[7:0], win};
                tail_cnt_reg <= 1'b1;
                if (tail_last) begin
                    tail_reg <= 1'b0;
                end
            end
        end
    end

    // characters to the user side, one pulse each
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rx_char_reg <= '0;
            char_ready_reg <= 1'b0;
            framed_reg <= 1'b0;
        end else if (ce) begin
            char_ready_reg <= char_ev;
            framed_reg <= (st_reg == ST_FRAMED);
            if (char_ev) begin
                rx_char_reg <= win;
            end
        end
    end

    // sticky events; a set in the cycle of its clear still lands
    always_comb begin
        sts_set = '0;
        sts_set[S_CHAR] = char_ev;
        sts_set[S_SYNC] = sync_found;
        sts_set[S_GOOD] = cmp_reg & good;
        sts_set[S_BAD] = cmp_reg & ~good;
        sts_set[S_OVR] = char_ev & sts_reg[S_CHAR];
        sts_set[S_DROP] = dropout;
        sts_w1c = '0;
        if (wr && wb_adr_i == A_STAT) begin
            sts_w1c = wb_dat_i[NSTS-1:0];
        end
    end

    // status and interrupt
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sts_reg <= '0;
            irq_reg <= 1'b0;
        end else if (ce) begin
            sts_reg <= (sts_reg & ~sts_w1c) | sts_set;
            irq_reg <= |(sts_reg & mask_reg);
        end
    end

    // bus answer one cycle after the request; unmapped reads give zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else if (ce) begin
            ack_reg <= req;
            if (req) begin
                unique case (wb_adr_i)
                    A_CTRL: dat_reg <= DW'({dual_reg, mode_reg, 1'b0, en_reg});
                    A_SYNC: dat_reg <= DW'(sync_reg);
                    A_STAT: dat_reg <= DW'(sts_reg);
                    A_MASK: dat_reg <= DW'(mask_reg);
                    A_DATA: dat_reg <= DW'(rx_char_reg);
                    A_CHK: dat_reg <= {rcv_reg, chk.acc};
                    A_STATE: dat_reg <= DW'({tail_reg, st_reg});
                    default: dat_reg <= '0;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign irq = irq_reg;
    assign rx_char = rx_char_reg;
    assign char_ready = char_ready_reg;
    assign framed = framed_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    a_hunt_entry: assert property (
        ce && enter_search |=> st_reg == ST_HUNT && cnt_reg == '0)
        else $error("search not entered");
    a_single_sync: assert property (
        ce && en_next && !enter_search && bit_ev && st_reg == ST_HUNT
        && match && !dual_reg |=> st_reg == ST_FRAMED && sts_reg[S_SYNC])
        else $error("sync match did not frame");
    a_keep_search: assert property (
        ce && en_next && !enter_search && bit_ev && st_reg == ST_HUNT
        && !match |=> st_reg == ST_HUNT)
        else $error("left search without a match");
    a_dual_first: assert property (
        ce && en_next && !enter_search && bit_ev && st_reg == ST_HUNT
        && match && dual_reg |=> st_reg == ST_HUNT2 && !$rose(sts_reg[S_SYNC]))
        else $error("framed on a single sync in dual mode");
    a_dual_miss: assert property (
        ce && en_next && !enter_search && bit_ev && st_reg == ST_HUNT2
        && cnt_reg == CNT_LAST && !match |=> st_reg == ST_HUNT)
        else $error("second sync missing but framed");
    a_char_pulse: assert property (
        ce && char_ev |=> char_ready && rx_char == $past(win) && sts_reg[S_CHAR])
        else $error("character not delivered");
    a_verdict_flag: assert property (
        ce && cmp_reg |=> ($past(good) ? sts_reg[S_GOOD] && !$rose(sts_reg[S_BAD])
        : sts_reg[S_BAD] && !$rose(sts_reg[S_GOOD])))
        else $error("block check verdict wrong");
    a_sample_edge: assert property (
        ce && $past(ce) && bit_ev |-> $past(lclk_f_reg) && !$past(lclk_d_reg))
        else $error("bit taken without a clock edge");
    a_ack_drop: assert property (
        ce && ack_reg |=> !ack_reg)
        else $error("ack held two cycles");
endmodule

// *** scf_modem.sv ***
// scf_modem: behavioural synchronous modem, bit clock plus serial data
`timescale 1ns/1ps
module scf_modem (
    output logic line_clk,
    output logic line_data
);
    // clock rests low between frames; data never keeps its last value
    initial begin
        line_clk = 1'b0;
        line_data = 1'b0;
    end
    // n low bits of c, bit 0 first, 80 ns low then 80 ns high per bit
    task automatic send(input logic [7:0] c, input int n);
        for (int i = 0; i < n; i++) begin
            line_data = c[i];
            #80 line_clk = 1'b1;
            #80 line_clk = 1'b0;
        end
        // released line shows the inverse so a stale bit cannot pass
        line_data = ~c[n-1];
    endtask
endmodule

// *** scf_framer_tb.sv ***
// scf_framer_tb: self-checking bench for sync search, framing and block check
`timescale 1ns/1ps
module scf_framer_tb;
    import scf_pkg::*;
    logic mclk = 1'b0; // system clock
    logic nrst = 1'b0; // reset, active low
    logic cyc = 1'b0; // bus request
    logic ce = 1'b1; // clock enable
    logic we = 1'b0; // bus direction
    logic [7:0] adr = 8'h00; // bus address
    logic [31:0] wdat = 32'h0; // bus write data
    logic [31:0] rdat, dat_o; // read data taken, read data port
    logic ack, irq, char_ready, framed, line_clk, line_data;
    logic [7:0] rx_char, b;
    logic [15:0] acc; // expected check value
    logic [7:0] exp_q[$]; // expected characters, oldest first
    logic [7:0] ra[5] = '{A_CTRL, A_SYNC, A_STAT, A_MASK, 8'h1c};
    int seed = 32'h10af;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc_cnt = 0;
    // free-running 100 MHz clock
    always #5 mclk = ~mclk;
    scf_modem m (.line_clk(line_clk), .line_data(line_data));
    scf_framer #(.DROP_CYCLES(200)) uut (.mclk(mclk), .nrst(nrst), .ce(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .line_clk(line_clk), .line_data(line_data), .irq(irq),
        .rx_char(rx_char), .char_ready(char_ready), .framed(framed));
    // counts and verdict, the only way out of the run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no cycle count assumed; a hang ends at the bench timeout
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    // sender side check: per-bit xor or modulo-2 division, bit 0 first
    function automatic logic [15:0] fold(input logic [15:0] a, input logic [7:0] c,
        input int md);
        logic [15:0] p;
        logic f;
        if (md == 0) return a ^ {8'h00, c};
        p = (md == 1) ? POLY_CRC16 : POLY_CCITT;
        for (int i = 0; i < 8; i++) begin
            f = a[15] ^ c[i];
            a = {a[14:0], 1'b0} ^ (f ? p : 16'h0000);
        end
        return a;
    endfunction
    // watcher: each character pulse takes the oldest note
    always @(posedge mclk) begin
        cyc_cnt++;
        if (cyc_cnt > 40000) begin
            error_cnt++;
            tally_and_finish();
        end else if (char_ready === 1'b1) begin
            if (exp_q.size() == 0) chk({24'h0, rx_char}, 32'h100);
            else chk({24'h0, rx_char}, {24'h0, exp_q.pop_front()});
        end
    end
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        // reset values, unmapped hole reads zero
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk(rdat, (ra[i] == A_SYNC) ? 32'h16 : 32'h0);
        end
        $display("test reset done");
        wb(1'b1, A_MASK, 32'hc);
        wb(1'b1, A_CTRL, 32'h1);
        m.send(8'h05, 3); // misaligned lead-in slides the window
        m.send(SYNC_RST, 8);
        repeat (3) @(posedge mclk);
        chk(framed, 1);
        $display("test framing done");
        for (int md = 0; md < 3; md++) begin
            wb(1'b1, A_CTRL, 32'h21 | (32'(md) << 2));
            acc = 16'h0;
            repeat (3) begin
                b = 8'($random(seed));
                exp_q.push_back(b);
                acc = fold(acc, b, md);
                m.send(b, 8);
            end
            wb(1'b0, A_CHK, 32'h0);
            chk(rdat & 32'hffff, {16'h0, acc});
            wb(1'b1, A_CTRL, 32'h41 | (32'(md) << 2));
            if (md == 2) acc = acc ^ 16'h1; // corrupt the last block
            if (md != 0) begin
                exp_q.push_back(acc[15:8]);
                m.send(acc[15:8], 8);
            end
            exp_q.push_back(acc[7:0]);
            m.send(acc[7:0], 8);
            repeat (5) @(posedge mclk);
            chk(irq, 1);
            wb(1'b0, A_STAT, 32'h0);
            chk(rdat & 32'hc, (md == 2) ? 32'h8 : 32'h4);
            wb(1'b1, A_STAT, 32'h3f);
            repeat (2) @(posedge mclk);
            chk(irq, 0);
            $display("test check mode %0d done", md);
        end
        wb(1'b1, A_CTRL, 32'h13);
        m.send(SYNC_RST, 8);
        chk(framed, 0);
        m.send(8'h00, 8);
        m.send(SYNC_RST, 8);
        m.send(SYNC_RST, 8);
        chk(framed, 1);
        b = 8'($random(seed));
        exp_q.push_back(b);
        m.send(b, 8);
        $display("test dual sync done");
        // a frozen block must not count silence toward a dropout
        @(posedge mclk);
        ce <= 1'b0;
        repeat (300) @(posedge mclk);
        chk(framed, 1);
        ce <= 1'b1;
        $display("test clock enable done");
        repeat (300) @(posedge mclk);
        chk(framed, 0);
        chk(irq, 0);
        wb(1'b0, A_STAT, 32'h0);
        chk(rdat & 32'h20, 32'h20);
        chk(exp_q.size(), 0);
        $display("test dropout done");
        tally_and_finish();
    end
endmodule
